// File: core/nibble_ops_pkg.sv
// opcode encodings, widths and decode helpers for the branch/io execution core
// assumes a 10-bit instruction word and a 4-bit data path
package nibble_ops_pkg;
    localparam int PC_W    = 14;
    localparam int IW      = 10;
    localparam int DA_W    = 10;
    localparam int NIB     = 4;
    localparam int W_W     = 2;
    localparam int STK_AW  = 4;
    localparam int STK_D   = 16;
    localparam int D_N     = 16;
    localparam int R_N     = 16;
    localparam int PAGE_LO = 8;
    localparam logic [1:0] WORD_ALIGN = 2'h0;

    typedef enum {
        st_fetch, st_opnd, st_call2, st_ret1, st_ret2, st_pat2, st_standby, st_stop
    } state_t;

    typedef enum {
        op_nop, op_serial_kick, op_imm_neq_mem, op_acc_neq_mem, op_b_neq_mem, op_y_neq_imm,
        op_imm_le_mem, op_acc_le_mem, op_b_le_mem, op_acc_le_imm,
        op_set_ram_bit, op_clear_ram_bit, op_test_ram_bit,
        op_cond_short_jump, op_cond_far_jump, op_far_jump, op_short_call, op_far_call,
        op_table_jump, op_subr_return, op_intr_return,
        op_set_d_latch_indexed, op_set_d_latch_direct, op_clear_d_latch_indexed,
        op_clear_d_latch_direct, op_test_d_latch_indexed, op_test_d_latch_direct,
        op_acc_from_r_port, op_b_from_r_port, op_r_port_from_acc, op_r_port_from_b,
        op_pattern, op_standby_enter, op_stop_enter
    } op_t;

    function automatic op_t decode(input logic [IW-1:0] w);
        casez (w)
            10'b11????????: decode = op_cond_short_jump;
            10'h004, 10'h104: decode = op_acc_neq_mem;
            10'h084: decode = op_b_neq_mem;
            10'b000111????: decode = op_y_neq_imm;
            10'b0?0010????: decode = op_imm_neq_mem;
            10'b0?0011????: decode = op_imm_le_mem;
            10'h014, 10'h114: decode = op_acc_le_mem;
            10'h0c4: decode = op_b_le_mem;
            10'b000101????: decode = op_acc_le_imm;
            10'b00100100??, 10'b01100001??: decode = op_set_ram_bit;
            10'b00100101??, 10'b01100101??: decode = op_clear_ram_bit;
            10'b00100110??, 10'b01100010??: decode = op_test_ram_bit;
            10'b010101????: decode = op_far_jump;
            10'b010110????: decode = op_far_call;
            10'b010111????: decode = op_cond_far_jump;
            10'b01110?????: decode = op_short_call;
            10'b001011????: decode = op_table_jump;
            10'h010: decode = op_subr_return;
            10'h011: decode = op_intr_return;
            10'h0e4: decode = op_set_d_latch_indexed;
            10'h064: decode = op_clear_d_latch_indexed;
            10'h0e0: decode = op_test_d_latch_indexed;
            10'b101110????: decode = op_set_d_latch_direct;
            10'b101010????: decode = op_clear_d_latch_direct;
            10'b101111????: decode = op_test_d_latch_direct;
            10'b100101????: decode = op_acc_from_r_port;
            10'b100100????: decode = op_b_from_r_port;
            10'b100110????: decode = op_r_port_from_acc;
            10'b101100????: decode = op_r_port_from_b;
            10'b011111????: decode = op_pattern;
            10'h148: decode = op_serial_kick;
            10'h14c: decode = op_standby_enter;
            10'h14d: decode = op_stop_enter;
            default: decode = op_nop;
        endcase
    endfunction : decode

    // words whose second word is a ram address or a far target
    function automatic logic two_word(input logic [IW-1:0] w);
        casez (w)
            10'h104, 10'h114, 10'b01001?????, 10'b0110??????, 10'b010101????, 10'b01011?????:
                two_word = 1'b1;
            default: two_word = 1'b0;
        endcase
    endfunction : two_word
endpackage : nibble_ops_pkg

// File: core/nibble_cpu_branch_io_ops.sv
// execution core for compare, ram bit, branch/call/return, io and power control words
// assumes asynchronous-read program rom and data ram on the same clock
//
// Contract
// RULE1: imm_neq_mem sets status when immediate differs
// RULE2: acc_neq_mem sets status when accumulator differs
// RULE3: b_neq_mem sets status, one cycle
// RULE4: y_neq_imm sets status when y differs
// RULE5: imm_le_mem sets no-borrow status
// RULE6: acc_le_mem sets no-borrow status
// RULE7: b_le_mem sets no-borrow status
// RULE8: acc_le_imm sets no-borrow status
// RULE9: ram bit set, clear, test by index
// RULE10: short jump on status, in page
// RULE11: far jump on status, page plus address
// RULE12: short call on status, two cycles
// RULE13: far call on status, two words
// RULE14: table jump by register select, one cycle
// RULE15: subroutine return takes three cycles
// RULE16: interrupt return enables, restores carry, status
// RULE17: d latch set, clear, test
// RULE18: r port nibble moves both directions
// RULE19: pattern fetch reads rom, two cycles
// RULE20: zero word only advances program counter
// RULE21: standby and stop enter low power
// RULE22: serial start acts as no-operation
// RULE23: failed condition falls through, status set
// RULE24: cycle counts fixed per instruction
`timescale 1ns/10ps
`default_nettype none
module nibble_cpu_branch_io_ops
    import nibble_ops_pkg::*;
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire logic               ce,
    // program rom
    output logic [PC_W-1:0]         rom_addr,
    input  wire logic [IW-1:0]      rom_data,
    // data ram
    output logic [DA_W-1:0]         ram_addr,
    output logic [NIB-1:0]          ram_wdata,
    output logic                    ram_we,
    input  wire logic [NIB-1:0]     ram_rdata,
    // register preload from the rest of the core
    input  wire logic               core_load,
    input  wire logic [NIB-1:0]     core_acc,
    input  wire logic [NIB-1:0]     core_b,
    input  wire logic [W_W-1:0]     core_w,
    input  wire logic [NIB-1:0]     core_x,
    input  wire logic [NIB-1:0]     core_y,
    input  wire logic               core_cy,
    // pins
    output logic [D_N-1:0]          d_out,
    input  wire logic [D_N-1:0]     d_in,
    output logic [R_N*NIB-1:0]      r_out,
    input  wire logic [R_N*NIB-1:0] r_in,
    input  wire logic               wake_pin,
    // state seen by the core
    output logic                    standby_o,
    output logic                    stop_o,
    output logic                    st_o,
    output logic                    cy_o,
    output logic                    ie_o,
    output logic [NIB-1:0]          acc_o,
    output logic [NIB-1:0]          b_o
);

    localparam int STK_W = PC_W + 2;

    state_t                 state_r;
    logic [PC_W-1:0]        pc_r;
    logic [IW-1:0]          ir_r;
    logic [NIB-1:0]         acc_r, b_r, x_r, y_r;
    logic [W_W-1:0]         w_r;
    logic                   st_r, cy_r, ie_r;
    logic [STK_AW-1:0]      sp_r;
    logic [STK_W-1:0]       stk [STK_D];
    logic [PC_W-1:0]        pat_addr_r;
    logic [D_N-1:0]         d_out_r, d_in_m, d_in_s;
    logic [R_N*NIB-1:0]     r_out_r, r_in_m, r_in_s;
    logic                   wake_m, wake_s;

    logic [IW-1:0]          cw;
    op_t                    op;
    logic                   two, exec_v, cmp_neq, cmp_le, push, pop_ret;
    logic [NIB-1:0]         cmp_a, cmp_b, sel, bit_mask, dl_idx;
    logic [PC_W-1:0]        short_tgt, far_tgt, call_tgt, tbl_tgt, pc_inc;
    logic [STK_W-1:0]       top;

    function automatic logic [NIB-1:0] onehot(input logic [1:0] n);
        onehot = NIB'(1) << n;
    endfunction : onehot

    // -------------------------------------------------------------
    // decode and operand paths
    // -------------------------------------------------------------
    // second word of a two-word form arrives while the first sits in ir_r
    assign cw        = (state_r == st_opnd || state_r == st_call2) ? ir_r : rom_data;
    assign op        = decode(cw);
    assign two       = two_word(cw);
    assign exec_v    = ce && ((state_r == st_fetch && !two) || state_r == st_opnd);
    assign sel       = cw[NIB-1:0];
    assign bit_mask  = onehot(cw[1:0]);
    assign pc_inc    = pc_r + PC_W'(1);
    assign short_tgt = {pc_r[PC_W-1:PAGE_LO], cw[PAGE_LO-1:0]};
    assign far_tgt   = {ir_r[NIB-1:0], rom_data};
    assign call_tgt  = PC_W'({ir_r[4:0], WORD_ALIGN});
    assign tbl_tgt   = {sel, b_r, acc_r, WORD_ALIGN};
    assign top       = stk[sp_r - STK_AW'(1)];
    assign dl_idx    = (op == op_set_d_latch_indexed || op == op_clear_d_latch_indexed ||
                        op == op_test_d_latch_indexed) ? y_r : sel;

    always_comb begin
        unique case (op)
            op_imm_neq_mem, op_imm_le_mem: cmp_a = sel;
            op_acc_neq_mem, op_acc_le_mem, op_acc_le_imm: cmp_a = acc_r;
            op_b_neq_mem, op_b_le_mem: cmp_a = b_r;
            default: cmp_a = y_r;
        endcase
        cmp_b   = (op == op_y_neq_imm || op == op_acc_le_imm) ? sel : ram_rdata;
        cmp_neq = cmp_a != cmp_b;
        cmp_le  = cmp_a <= cmp_b;
    end

    // indirect address is the w:x:y pointer, direct is the second word
    assign ram_addr  = (state_r == st_opnd) ? rom_data : {w_r, x_r, y_r};
    assign ram_we    = exec_v && (op == op_set_ram_bit || op == op_clear_ram_bit);   // [RULE9]
    assign ram_wdata = (op == op_set_ram_bit) ? (ram_rdata | bit_mask) : (ram_rdata & ~bit_mask);
    assign rom_addr  = (state_r == st_pat2) ? pat_addr_r : pc_r;
    assign push      = ce && st_r && ((state_r == st_opnd && op == op_far_call) || state_r == st_call2);
    assign pop_ret   = ce && state_r == st_ret2;

    // -------------------------------------------------------------
    // sequencing and program counter
    // -------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r    <= st_fetch;
            pc_r       <= '0;
            ir_r       <= '0;
            pat_addr_r <= '0;
        end else if (ce) begin
            unique case (state_r)
                st_fetch: begin
                    pc_r <= pc_inc;                                      // [RULE20] [RULE22]
                    ir_r <= rom_data;                                    // [RULE16]
                    if (two) begin
                        state_r <= st_opnd;                              // [RULE24]
                    end else begin
                        unique case (op)
                            op_cond_short_jump: if (st_r) pc_r <= short_tgt;   // [RULE10]
                            op_short_call: state_r <= st_call2;          // [RULE12]
                            op_subr_return, op_intr_return: state_r <= st_ret1;   // [RULE15]
                            op_table_jump: pc_r <= tbl_tgt;              // [RULE14]
                            op_pattern: begin
                                pat_addr_r <= tbl_tgt;                   // [RULE19]
                                state_r    <= st_pat2;
                            end
                            op_standby_enter: state_r <= st_standby;     // [RULE21]
                            op_stop_enter: state_r <= st_stop;           // [RULE21]
                            default: ;
                        endcase
                    end
                end
                st_opnd: begin
                    pc_r    <= pc_inc;
                    state_r <= st_fetch;
                    if (op == op_far_jump || ((op == op_cond_far_jump || op == op_far_call) && st_r))
                        pc_r <= far_tgt;                                 // [RULE11] [RULE13] [RULE23]
                end
                st_call2: begin
                    if (st_r) pc_r <= call_tgt;                          // [RULE12] [RULE23]
                    state_r <= st_fetch;
                end
                st_ret1: state_r <= st_ret2;
                st_ret2: begin
                    pc_r    <= top[PC_W-1:0];                            // [RULE15]
                    state_r <= st_fetch;
                end
                st_pat2: state_r <= st_fetch;
                st_standby, st_stop: if (wake_s) state_r <= st_fetch;
            endcase
        end
    end

    // -------------------------------------------------------------
    // return stack
    // -------------------------------------------------------------
    // entry holds status and carry above the return address
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sp_r <= '0;
        end else if (push) begin
            stk[sp_r] <= {st_r, cy_r, (state_r == st_opnd) ? pc_inc : pc_r};   // [RULE13]
            sp_r      <= sp_r + STK_AW'(1);
        end else if (pop_ret) begin
            sp_r <= sp_r - STK_AW'(1);
        end
    end

    // -------------------------------------------------------------
    // working registers and status
    // -------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_r <= '0;
            b_r   <= '0;
            w_r   <= '0;
            x_r   <= '0;
            y_r   <= '0;
            st_r  <= 1'b1;
            cy_r  <= 1'b0;
            ie_r  <= 1'b0;
        end else if (ce) begin
            if (exec_v) begin
                unique case (op)
                    op_imm_neq_mem, op_acc_neq_mem, op_b_neq_mem, op_y_neq_imm:
                        st_r <= cmp_neq;                                 // [RULE1] [RULE2] [RULE3] [RULE4]
                    op_imm_le_mem, op_acc_le_mem, op_b_le_mem, op_acc_le_imm:
                        st_r <= cmp_le;                                  // [RULE5] [RULE6] [RULE7] [RULE8]
                    op_test_ram_bit: st_r <= |(ram_rdata & bit_mask);    // [RULE9]
                    op_cond_short_jump, op_cond_far_jump, op_far_call:
                        st_r <= 1'b1;                                    // [RULE23]
                    op_test_d_latch_indexed, op_test_d_latch_direct:
                        st_r <= d_in_s[dl_idx];                          // [RULE17]
                    op_acc_from_r_port: acc_r <= r_in_s[sel*NIB +: NIB];   // [RULE18]
                    op_b_from_r_port: b_r <= r_in_s[sel*NIB +: NIB];     // [RULE18]
                    default: ;
                endcase
            end
            if (state_r == st_call2) st_r <= 1'b1;                       // [RULE23]
            if (state_r == st_pat2) begin
                b_r   <= rom_data[2*NIB-1:NIB];                          // [RULE19]
                acc_r <= rom_data[NIB-1:0];
            end
            if (state_r == st_ret2 && decode(ir_r) == op_intr_return) begin
                ie_r <= 1'b1;                                            // [RULE16]
                st_r <= top[STK_W-1];
                cy_r <= top[STK_W-2];
            end
            if (core_load) begin
                acc_r <= core_acc;
                b_r   <= core_b;
                w_r   <= core_w;
                x_r   <= core_x;
                y_r   <= core_y;
                cy_r  <= core_cy;
            end
        end
    end

    // the first word of each instruction stays in ir_r, so the last return cycle knows which kind it is
    // -------------------------------------------------------------
    // discrete and r port latches
    // -------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            d_out_r <= '0;
            r_out_r <= '0;
        end else if (exec_v) begin
            unique case (op)
                op_set_d_latch_indexed, op_set_d_latch_direct: d_out_r[dl_idx] <= 1'b1;       // [RULE17]
                op_clear_d_latch_indexed, op_clear_d_latch_direct: d_out_r[dl_idx] <= 1'b0;   // [RULE17]
                op_r_port_from_acc: r_out_r[sel*NIB +: NIB] <= acc_r;   // [RULE18]
                op_r_port_from_b: r_out_r[sel*NIB +: NIB] <= b_r;       // [RULE18]
                default: ;
            endcase
        end
    end

    // -------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            d_in_m <= '0;
            d_in_s <= '0;
            r_in_m <= '0;
            r_in_s <= '0;
            wake_m <= 1'b0;
            wake_s <= 1'b0;
        end else if (ce) begin
            d_in_m <= d_in;
            d_in_s <= d_in_m;
            r_in_m <= r_in;
            r_in_s <= r_in_m;
            wake_m <= wake_pin;
            wake_s <= wake_m;
        end
    end

    assign d_out     = d_out_r;
    assign r_out     = r_out_r;
    assign standby_o = state_r == st_standby;
    assign stop_o    = state_r == st_stop;
    assign st_o      = st_r;
    assign cy_o      = cy_r;
    assign ie_o      = ie_r;
    assign acc_o     = acc_r;
    assign b_o       = b_r;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    logic in_fetch;
    assign in_fetch = ce && state_r == st_fetch && !core_load;

    a_imm_neq_flag: assert property (@(posedge clk) disable iff (!reset_n)   // [RULE1]
        exec_v && op == op_imm_neq_mem |=> st_r == $past(cmp_neq))
        else $error("immediate compare status wrong");
    a_acc_le_flag: assert property (@(posedge clk) disable iff (!reset_n)    // [RULE6]
        exec_v && op == op_acc_le_mem |=> st_r == $past(cmp_le))
        else $error("no-borrow status wrong");
    a_short_jump: assert property (@(posedge clk) disable iff (!reset_n)     // [RULE10]
        in_fetch && !two && op == op_cond_short_jump && st_r |=> pc_r == $past(short_tgt))
        else $error("short jump target wrong");
    a_fall_through: assert property (@(posedge clk) disable iff (!reset_n)   // [RULE23]
        in_fetch && !two && op == op_cond_short_jump && !st_r |=> st_r && pc_r == $past(pc_inc))
        else $error("failed branch did not fall through");
    a_return_len: assert property (@(posedge clk) disable iff (!reset_n)     // [RULE15]
        in_fetch && op == op_subr_return |=> state_r == st_ret1 ##1 (state_r == st_ret2 || !$past(ce)))
        else $error("return sequence wrong");
    a_call_len: assert property (@(posedge clk) disable iff (!reset_n)       // [RULE12]
        ce && state_r == st_call2 |=> state_r == st_fetch)
        else $error("short call not two cycles");
    a_stop_enter: assert property (@(posedge clk) disable iff (!reset_n)     // [RULE21]
        in_fetch && op == op_stop_enter |=> stop_o && !standby_o)
        else $error("stop not entered");
    a_bit_write: assert property (@(posedge clk) disable iff (!reset_n)      // [RULE9]
        ram_we |-> ((ram_wdata & bit_mask) != '0) == (op == op_set_ram_bit))
        else $error("ram bit write wrong");
endmodule : nibble_cpu_branch_io_ops
`default_nettype wire

// File: test/nibble_cpu_branch_io_ops_test.sv
// self-checking bench for the branch/io execution core
// assumes rom_data is presented per cycle by the bench and a 1k x 4 ram model answers ram_addr
`timescale 1ns/10ps
`default_nettype none
module nibble_cpu_branch_io_ops_test;
    import nibble_ops_pkg::*;
    typedef struct {
        logic [9:0] w1; logic [9:0] w2; int n; logic [3:0] acc; logic [3:0] b; logic [3:0] y;
        logic [3:0] mem; logic chk; logic st; logic [3:0] emem;
    } row_t;
    logic               clk = 1'b0;
    logic               reset_n = 1'b0;
    logic               ce = 1'b1;
    logic [IW-1:0]      rom_data = '0;
    logic               core_load = 1'b0;
    logic [NIB-1:0]     core_acc = '0, core_b = '0, core_x = '0, core_y = '0;
    logic [W_W-1:0]     core_w = '0;
    logic               core_cy = 1'b0;
    logic [D_N-1:0]     d_in = 16'h0200;
    logic [R_N*NIB-1:0] r_in = 64'h0000_0000_0000_6000;
    logic               wake_pin = 1'b0;
    logic [PC_W-1:0]    rom_addr, pc0;
    logic [DA_W-1:0]    ram_addr, addr;
    logic [NIB-1:0]     ram_wdata, ram_rdata, acc_o, b_o;
    logic               ram_we, standby_o, stop_o, st_o, cy_o, ie_o;
    logic [D_N-1:0]     d_out;
    logic [R_N*NIB-1:0] r_out;
    logic [3:0]         ram [0:1023];
    int                 num_errors = 0, num_checks = 0, cycles = 0;
    // ----------------------------------------
    // clock, ram model, hang guard
    // ----------------------------------------
    always #4 clk = ~clk;
    assign ram_rdata = ram[ram_addr];
    always @(posedge clk) begin
        if (ram_we === 1'b1) ram[ram_addr] <= ram_wdata;
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            complete_run();
        end
    end
    nibble_cpu_branch_io_ops uut (.clk(clk), .reset_n(reset_n), .ce(ce), .rom_addr(rom_addr), .rom_data(rom_data),
        .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_we(ram_we), .ram_rdata(ram_rdata), .core_load(core_load),
        .core_acc(core_acc), .core_b(core_b), .core_w(core_w), .core_x(core_x), .core_y(core_y), .core_cy(core_cy),
        .d_out(d_out), .d_in(d_in), .r_out(r_out), .r_in(r_in), .wake_pin(wake_pin), .standby_o(standby_o),
        .stop_o(stop_o), .st_o(st_o), .cy_o(cy_o), .ie_o(ie_o), .acc_o(acc_o), .b_o(b_o));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one word presented for one clock, inputs settle 1 ns after the edge
    task automatic cyc(input logic [9:0] w);
        rom_data = w;
        @(posedge clk);
        #1;
    endtask : cyc
    // preload costs one nop cycle, so pc moves by one
    task automatic load(input logic [3:0] a, input logic [3:0] b, input logic [3:0] y, input logic cy);
        core_acc = a; core_b = b; core_y = y; core_cy = cy; core_load = 1'b1;
        cyc(10'h000);
        core_load = 1'b0;
    endtask : load
    task automatic clr_st;
        load(4'h0, 4'h0, 4'h0, 1'b0);
        ram[0] = 4'h0;
        cyc(10'h020);
    endtask : clr_st
    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    // ----------------------------------------
    // ordinary cases: compare, bit ops, nop
    // ----------------------------------------
    row_t rows [] = '{
        '{10'h025, 10'h000, 1, 4'h0, 4'h0, 4'h1, 4'h5, 1'b1, 1'b0, 4'h5},
        '{10'h125, 10'h155, 2, 4'h0, 4'h0, 4'h1, 4'h6, 1'b1, 1'b1, 4'h6},
        '{10'h004, 10'h000, 1, 4'h3, 4'h0, 4'h2, 4'h3, 1'b1, 1'b0, 4'h3},
        '{10'h104, 10'h1a3, 2, 4'h3, 4'h0, 4'h2, 4'h4, 1'b1, 1'b1, 4'h4},
        '{10'h084, 10'h000, 1, 4'h0, 4'h9, 4'h3, 4'h9, 1'b1, 1'b0, 4'h9},
        '{10'h07a, 10'h000, 1, 4'h0, 4'h0, 4'ha, 4'h0, 1'b1, 1'b0, 4'h0},
        '{10'h07a, 10'h000, 1, 4'h0, 4'h0, 4'hb, 4'h0, 1'b1, 1'b1, 4'h0},
        '{10'h037, 10'h000, 1, 4'h0, 4'h0, 4'h4, 4'h7, 1'b1, 1'b1, 4'h7},
        '{10'h138, 10'h2c7, 2, 4'h0, 4'h0, 4'h4, 4'h7, 1'b1, 1'b0, 4'h7},
        '{10'h014, 10'h000, 1, 4'hf, 4'h0, 4'h5, 4'he, 1'b1, 1'b0, 4'he},
        '{10'h114, 10'h3ff, 2, 4'h0, 4'h0, 4'h5, 4'h0, 1'b1, 1'b1, 4'h0},
        '{10'h0c4, 10'h000, 1, 4'h0, 4'h4, 4'h6, 4'h5, 1'b1, 1'b1, 4'h5},
        '{10'h056, 10'h000, 1, 4'h7, 4'h0, 4'h6, 4'h0, 1'b1, 1'b0, 4'h0},
        '{10'h056, 10'h000, 1, 4'h6, 4'h0, 4'h6, 4'h0, 1'b1, 1'b1, 4'h0},
        '{10'h093, 10'h000, 1, 4'h0, 4'h0, 4'h7, 4'h0, 1'b0, 1'b0, 4'h8},
        '{10'h194, 10'h201, 2, 4'h0, 4'h0, 4'h7, 4'hf, 1'b0, 1'b0, 4'he},
        '{10'h09a, 10'h000, 1, 4'h0, 4'h0, 4'h8, 4'h4, 1'b1, 1'b1, 4'h4},
        '{10'h189, 10'h202, 2, 4'h0, 4'h0, 4'h8, 4'hd, 1'b1, 1'b0, 4'hd},
        '{10'h000, 10'h000, 1, 4'h0, 4'h0, 4'h9, 4'h3, 1'b0, 1'b0, 4'h3},
        '{10'h148, 10'h000, 1, 4'h0, 4'h0, 4'h9, 4'h3, 1'b0, 1'b0, 4'h3}};
    initial begin
        repeat (10) @(posedge clk);
        #1;
        reset_n = 1'b1;
        check("reset pc", rom_addr, 0);
        check("reset flags", {st_o, cy_o, ie_o, standby_o, stop_o}, 5'b10000);
        check("reset regs", {acc_o, b_o, d_out}, 24'h0);
        check("reset r port", r_out, 64'h0);
        foreach (rows[i]) begin
            load(rows[i].acc, rows[i].b, rows[i].y, 1'b0);
            addr = (rows[i].n == 2) ? rows[i].w2 : {6'h0, rows[i].y};
            ram[addr] = rows[i].mem;
            pc0 = rom_addr;
            cyc(rows[i].w1);
            if (rows[i].n == 2) cyc(rows[i].w2);
            check("pc step", rom_addr, pc0 + rows[i].n);
            if (rows[i].chk) check("status", st_o, rows[i].st);
            check("ram nibble", ram[addr], rows[i].emem);
        end
        // ----------------------------------------
        // jumps, calls, returns
        // ----------------------------------------
        // y is 9 here, so this compare raises status before the taken jump
        cyc(10'h070); pc0 = rom_addr; cyc(10'h3a5);
        check("short jump", rom_addr, {pc0[13:8], 8'ha5});
        clr_st; pc0 = rom_addr; cyc(10'h3a5);
        check("short jump skip", {rom_addr, st_o}, {pc0 + 14'h1, 1'b1});
        cyc(10'h153); cyc(10'h2aa);
        check("far jump", rom_addr, {4'h3, 10'h2aa});
        cyc(10'h17c); cyc(10'h011);
        check("cond far jump", rom_addr, {4'hc, 10'h011});
        clr_st; pc0 = rom_addr; cyc(10'h17c); cyc(10'h011);
        check("cond far skip", {rom_addr, st_o}, {pc0 + 14'h2, 1'b1});
        load(4'h0, 4'h0, 4'h0, 1'b1); pc0 = rom_addr; cyc(10'h165); cyc(10'h0ff);
        check("far call", rom_addr, {4'h5, 10'h0ff});
        load(4'h0, 4'h0, 4'h0, 1'b0); clr_st; cyc(10'h011); cyc(10'h000); cyc(10'h000);
        check("intr return", {rom_addr, ie_o, cy_o, st_o}, {pc0 + 14'h2, 3'b111});
        pc0 = rom_addr; cyc(10'h1c5); cyc(10'h000);
        check("short call", rom_addr, {7'h0, 5'h05, 2'b00});
        cyc(10'h010); cyc(10'h000); cyc(10'h000);
        check("return", rom_addr, pc0 + 14'h1);
        clr_st; pc0 = rom_addr; cyc(10'h1c5); cyc(10'h000);
        check("short call skip", {rom_addr, st_o}, {pc0 + 14'h1, 1'b1});
        load(4'h3, 4'ha, 4'h0, 1'b0); cyc(10'h0b5);
        check("table jump", rom_addr, {4'h5, 4'ha, 4'h3, 2'b00});
        load(4'h3, 4'ha, 4'h0, 1'b0); pc0 = rom_addr; cyc(10'h1f6);
        check("pattern addr", rom_addr, {4'h6, 4'ha, 4'h3, 2'b00});
        cyc(10'h0c7);
        check("pattern data", {b_o, acc_o, rom_addr}, {4'hc, 4'h7, pc0 + 14'h1});
        // ----------------------------------------
        // discrete latches and r ports
        // ----------------------------------------
        load(4'h9, 4'h5, 4'h5, 1'b0); cyc(10'h0e4); cyc(10'h2e9);
        check("d set", d_out, 16'h0220);
        cyc(10'h064); check("d clear y", d_out, 16'h0200);
        cyc(10'h2a9); check("d clear m", d_out, 16'h0000);
        cyc(10'h0e0); check("d test y", st_o, 1'b0);
        cyc(10'h2f9); check("d test m", st_o, 1'b1);
        cyc(10'h26e); cyc(10'h2c1);
        check("r out", r_out, 64'h0900_0000_0000_0050);
        cyc(10'h253); cyc(10'h243);
        check("r in", {acc_o, b_o}, 8'h66);
        // ----------------------------------------
        // low power, wake, clock enable
        // ----------------------------------------
        pc0 = rom_addr; cyc(10'h14c); cyc(10'h3a5); cyc(10'h3a5);
        check("standby", {standby_o, stop_o, rom_addr}, {2'b10, pc0 + 14'h1});
        wake_pin = 1'b1; repeat (4) cyc(10'h000); wake_pin = 1'b0;
        check("standby wake", standby_o, 1'b0);
        // let the synchronised wake level drain, or stop would be left at once
        cyc(10'h000); cyc(10'h000);
        pc0 = rom_addr; cyc(10'h14d); cyc(10'h3a5);
        check("stop", {standby_o, stop_o, rom_addr}, {2'b01, pc0 + 14'h1});
        wake_pin = 1'b1; repeat (4) cyc(10'h000); wake_pin = 1'b0;
        check("stop wake", stop_o, 1'b0);
        ce = 1'b0; pc0 = rom_addr; cyc(10'h3a5);
        check("ce freeze", rom_addr, pc0);
        ce = 1'b1;
        complete_run();
    end
endmodule : nibble_cpu_branch_io_ops_test
`default_nettype wire
